/* hdl/rh_consts.vh */
// Register map, field positions and reset values of the root hub status block
`ifndef RH_CONSTS_VH
`define RH_CONSTS_VH

// ==========================================================
// Register byte addresses
`define RH_ADDR_HUB_STATUS 32'hB000_7050
`define RH_ADDR_PORT1_STATUS 32'hB000_7054
`define RH_ADDR_PORT2_STATUS 32'hB000_7058
`define RH_ADDR_HUB_CONTROL 32'hB000_7060
`define RH_ADDR_INT_STATUS 32'hB000_7064
`define RH_ADDR_INT_MASK 32'hB000_7068

// ==========================================================
// Hub status fields
`define RH_HS_CLR_RWE 31
`define RH_HS_OC_CHANGE 17
`define RH_HS_SET_GPWR 16
`define RH_HS_RWE 15
`define RH_HS_OC 1
`define RH_HS_CLR_GPWR 0

// ==========================================================
// Hub control fields
`define RH_HC_NO_OC_PROT 12
`define RH_HC_OC_MODE 11
`define RH_HC_PWR_MODE 8

// ==========================================================
// Port status fields
`define RH_PS_PRSC 20
`define RH_PS_OC_CHANGE 19
`define RH_PS_SUSP_CHANGE 18
`define RH_PS_EN_CHANGE 17
`define RH_PS_CSC 16
`define RH_PS_CLR_PPWR 9
`define RH_PS_PPS 8
`define RH_PS_POC 3
`define RH_PS_CC 0

// ==========================================================
// Interrupt status and mask fields
`define RH_INT_HUB_OC 0
`define RH_INT_PORT1_CSC 1
`define RH_INT_PORT2_CSC 2
`define RH_INT_WAKE 3
`define RH_INT_WIDTH 4

// ==========================================================
// Reset values
`define RH_RESET_WORD 32'h0000_0000

`endif

/* hdl/sticky_w1c.v */
// Vector of sticky flags, set by hardware, cleared by writing one
module sticky_w1c #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Set and clear strobes
  input wire [WIDTH-1:0] set_i,
  input wire [WIDTH-1:0] clr_i,
  // Flag state
  output reg [WIDTH-1:0] q_o
);

  // ==========================================================
  // Flag storage
  // A set in the clearing cycle wins, so no event is lost
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      q_o <= {WIDTH{1'b0}};
    else
      q_o <= (q_o & ~clr_i) | set_i;
  end

endmodule // sticky_w1c

/* hdl/rh_port.v */
// One root hub port: status flags, change flags and port power
`include "rh_consts.vh"

module rh_port (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Port line events
  input wire connect_i,
  input wire port_oc_i,
  input wire enable_lost_i,
  input wire resume_done_i,
  input wire reset_done_i,
  // Hub settings and global commands
  input wire oc_individual_i,
  input wire pwr_individual_i,
  input wire global_set_i,
  input wire global_clr_i,
  // Register access
  input wire wr_i,
  input wire [31:0] wdata_i,
  output wire [31:0] rdata_o,
  // Status out
  output wire csc_event_o,
  output reg power_o
);

  reg connect_q;
  reg poc_q;
  wire poc_now;
  wire [4:0] set_vec;
  wire [4:0] clr_vec;
  wire [4:0] flags;

  // ==========================================================
  // Change detection
  assign poc_now = port_oc_i & oc_individual_i;
  assign csc_event_o = connect_i ^ connect_q; // RULE_17
  assign set_vec = {reset_done_i, poc_now ^ poc_q, resume_done_i, enable_lost_i, csc_event_o};
  assign clr_vec = wr_i ? wdata_i[`RH_PS_PRSC:`RH_PS_CSC] : 5'h00;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      connect_q <= 1'b0;
      poc_q <= 1'b0;
    end
    else
    begin
      connect_q <= connect_i;
      poc_q <= poc_now;
    end
  end

  // Change flags, cleared by writing one
  sticky_w1c #(
    .WIDTH(5)
  ) u_flags (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .q_o(flags)
  );

  // ==========================================================
  // Port power: global commands in global mode, port writes otherwise
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      power_o <= 1'b0;
    else if (!pwr_individual_i) // RULE_15
    begin
      if (global_set_i)
        power_o <= 1'b1;
      else if (global_clr_i)
        power_o <= 1'b0;
    end
    else if (wr_i && wdata_i[`RH_PS_PPS])
      power_o <= 1'b1;
    else if (wr_i && wdata_i[`RH_PS_CLR_PPWR])
      power_o <= 1'b0;
  end

  // Read view
  assign rdata_o = {11'h000, flags, 7'h00, power_o, 4'h0, poc_q, 2'h0, connect_q};

endmodule // rh_port

/* hdl/usb_host_root_hub_status.v */
// Root hub status and command registers of a USB host controller, APB slave
//
// Summary of operation
// RULE_01 - Write one to bit 31 clears wake enable
// RULE_02 - Zero at bit 31 changes nothing; reads zero
// RULE_03 - Hub over-current change flag sets on toggle
// RULE_04 - Write one clears over-current change flag
// RULE_05 - Bit 16 always reads zero
// RULE_06 - Write one bit 16: set global power
// RULE_07 - Bit 15 reads wake enable; gates wakeup
// RULE_08 - Write one bit 15 sets wake enable
// RULE_09 - Over-current indicator follows over-current pin
// RULE_10 - Indicator valid only if both settings zero
// RULE_11 - Bit 0 always reads zero
// RULE_12 - Write one bit 0: clear global power
// RULE_13 - Hub status reads zero after reset
// RULE_14 - Two port status registers, reset zero
// RULE_15 - Power switching mode: global or per port
// RULE_16 - Over-current mode: global or per port
// RULE_17 - Connect change flag set on connect event
`include "rh_consts.vh"

module usb_host_root_hub_status #(
  parameter NUM_PORTS = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Hub over-current pin
  input wire overcurrent_input_pin_i,
  // Port line events
  input wire [NUM_PORTS-1:0] port_connect_i,
  input wire [NUM_PORTS-1:0] port_overcurrent_i,
  input wire [NUM_PORTS-1:0] port_enable_lost_i,
  input wire [NUM_PORTS-1:0] port_resume_done_i,
  input wire [NUM_PORTS-1:0] port_reset_done_i,
  // Port power and system signals
  output wire [NUM_PORTS-1:0] port_power_o,
  output reg remote_wakeup_o,
  output reg irq_o
);

  // ==========================================================
  // Address decode helpers
  // Map: hub status, two port status words, then three words of our own
  // (hub control, interrupt status, interrupt mask) after a one-word gap.
  // Any other address answers with an error and is otherwise ignored.

  // One-hot select of the six registers from a byte address
  function [5:0] reg_select;
    input [31:0] addr;
    begin
      reg_select[0] = (addr == `RH_ADDR_HUB_STATUS);
      reg_select[1] = (addr == `RH_ADDR_PORT1_STATUS);
      reg_select[2] = (addr == `RH_ADDR_PORT2_STATUS);
      reg_select[3] = (addr == `RH_ADDR_HUB_CONTROL);
      reg_select[4] = (addr == `RH_ADDR_INT_STATUS);
      reg_select[5] = (addr == `RH_ADDR_INT_MASK);
    end
  endfunction

  // One write-one command bit of a committed write
  function w1_cmd;
    input wr_hit;
    input [31:0] data;
    input integer pos;
    begin
      w1_cmd = wr_hit & data[pos];
    end
  endfunction

  // ==========================================================
  // Declarations
  wire [5:0] sel;
  wire setup_phase;
  wire wr_commit;
  wire [5:0] wr_sel;
  wire addr_mapped;
  reg remote_wake_enable_q;
  reg remote_wake_enable_d;
  reg no_oc_protection_q;
  reg oc_protection_mode_q;
  reg power_switching_mode_q;
  reg hub_overcurrent_flag_q;
  wire hub_oc_valid;
  wire hub_oc_now;
  wire hub_oc_changed;
  wire hub_oc_change_clr;
  wire hub_oc_change;
  wire set_global_power_cmd;
  wire clear_global_power_cmd;
  wire oc_individual;
  wire [NUM_PORTS-1:0] csc_event;
  wire [31:0] port_rdata [0:NUM_PORTS-1];
  wire [NUM_PORTS-1:0] port_wr;
  wire wake_event;
  reg [`RH_INT_WIDTH-1:0] int_mask_q;
  wire [`RH_INT_WIDTH-1:0] int_set;
  wire [`RH_INT_WIDTH-1:0] int_clr;
  wire [`RH_INT_WIDTH-1:0] int_status;
  reg [31:0] hub_status_rd;
  reg [31:0] rdata_d;

  // ==========================================================
  // APB phase tracking
  assign sel = reg_select(paddr_i);
  assign setup_phase = psel_i & ~penable_i;
  // Any address outside the six words is refused
  assign addr_mapped = |sel;

  // Writes take effect only at the edge where pready is sampled high
  assign wr_commit = psel_i & penable_i & pready_o & pwrite_i;
  assign wr_sel = wr_commit ? sel : 6'h00;

  // Answer is fixed at one access cycle: pready rises in the first access cycle.
  // Read data is captured in the setup cycle, so it is stable for the master.
  // A write answers with zero data, so nothing leaks onto the bus.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `RH_RESET_WORD;
    end
    else
    begin
      pready_o <= setup_phase;
      if (setup_phase)
      begin
        pslverr_o <= ~addr_mapped; // Unmapped address answers with an error
        prdata_o <= pwrite_i ? `RH_RESET_WORD : rdata_d;
      end
      else if (pready_o)
      begin
        pslverr_o <= 1'b0;
        prdata_o <= `RH_RESET_WORD;
      end
    end
  end

  // ==========================================================
  // Hub commands decoded from hub status writes
  // Command bits are not stored; they act once per write
  // Global commands reach every port; each port applies them by its mode
  assign set_global_power_cmd = w1_cmd(wr_sel[0], pwdata_i, `RH_HS_SET_GPWR); // RULE_06
  assign clear_global_power_cmd = w1_cmd(wr_sel[0], pwdata_i, `RH_HS_CLR_GPWR); // RULE_12

  // ==========================================================
  // Remote wake enable
  // Set and clear in one write: clear takes priority, as the safer outcome
  always @*
  begin
    remote_wake_enable_d = remote_wake_enable_q;
    if (w1_cmd(wr_sel[0], pwdata_i, `RH_HS_RWE))
      remote_wake_enable_d = 1'b1; // RULE_08
    if (w1_cmd(wr_sel[0], pwdata_i, `RH_HS_CLR_RWE))
      remote_wake_enable_d = 1'b0; // RULE_01 RULE_02
  end

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      remote_wake_enable_q <= 1'b0;
    else
      remote_wake_enable_q <= remote_wake_enable_d;
  end

  // ==========================================================
  // Hub control settings
  // Whole-word write; only three bits are kept, the rest read zero
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      no_oc_protection_q <= 1'b0;
      oc_protection_mode_q <= 1'b0;
      power_switching_mode_q <= 1'b0;
    end
    else if (wr_sel[3])
    begin
      no_oc_protection_q <= pwdata_i[`RH_HC_NO_OC_PROT];
      oc_protection_mode_q <= pwdata_i[`RH_HC_OC_MODE];
      power_switching_mode_q <= pwdata_i[`RH_HC_PWR_MODE];
    end
  end

  // ==========================================================
  // Hub over-current indicator
  // Outside global reporting the indicator is held low to avoid stale reports
  // Gating sits before the change detector, so a settings change counts too
  assign hub_oc_valid = ~no_oc_protection_q & ~oc_protection_mode_q; // RULE_10
  assign hub_oc_now = overcurrent_input_pin_i & hub_oc_valid; // RULE_09 RULE_16
  assign hub_oc_changed = hub_oc_now ^ hub_overcurrent_flag_q; // RULE_03
  assign hub_oc_change_clr = w1_cmd(wr_sel[0], pwdata_i, `RH_HS_OC_CHANGE); // RULE_04

  // The flag gives the pin one cycle of latency before it can be read

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      hub_overcurrent_flag_q <= 1'b0;
    else
      hub_overcurrent_flag_q <= hub_oc_now;
  end

  // Change flag; a change in the clearing cycle keeps it set
  sticky_w1c #(
    .WIDTH(1)
  ) u_hub_oc_change (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(hub_oc_changed),
    .clr_i(hub_oc_change_clr),
    .q_o(hub_oc_change)
  );

  // ==========================================================
  // Root hub ports
  // Per-port over-current only when protection is on and individual
  assign oc_individual = ~no_oc_protection_q & oc_protection_mode_q; // RULE_16

  // Port write enables follow the one-hot select, port 1 first
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1)
    begin : g_port
      assign port_wr[p] = wr_sel[p + 1]; // RULE_14
      rh_port u_port (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .connect_i(port_connect_i[p]),
        .port_oc_i(port_overcurrent_i[p]),
        .enable_lost_i(port_enable_lost_i[p]),
        .resume_done_i(port_resume_done_i[p]),
        .reset_done_i(port_reset_done_i[p]),
        .oc_individual_i(oc_individual),
        .pwr_individual_i(power_switching_mode_q),
        .global_set_i(set_global_power_cmd),
        .global_clr_i(clear_global_power_cmd),
        .wr_i(port_wr[p]),
        .wdata_i(pwdata_i),
        .rdata_o(port_rdata[p]),
        .csc_event_o(csc_event[p]),
        .power_o(port_power_o[p])
      );
    end
  endgenerate

  // ==========================================================
  // Remote wakeup
  // Only a connect change counts, and only while wake is enabled
  assign wake_event = remote_wake_enable_q & (|csc_event); // RULE_07

  // A pulse, not a level: software that misses it reads the interrupt flag

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      remote_wakeup_o <= 1'b0;
    else
      remote_wakeup_o <= wake_event; // One-cycle pulse
  end

  // ==========================================================
  // Interrupt status and mask
  // Event sources: hub change, two connect changes, wakeup
  // A clear write racing an event loses, so no event is dropped
  assign int_set = {wake_event, csc_event[1], csc_event[0], hub_oc_changed};
  assign int_clr = wr_sel[4] ? pwdata_i[`RH_INT_WIDTH-1:0] : {`RH_INT_WIDTH{1'b0}};

  sticky_w1c #(
    .WIDTH(`RH_INT_WIDTH)
  ) u_int_status (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(int_set),
    .clr_i(int_clr),
    .q_o(int_status)
  );

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      int_mask_q <= {`RH_INT_WIDTH{1'b0}};
    else if (wr_sel[5])
      int_mask_q <= pwdata_i[`RH_INT_WIDTH-1:0];
  end

  // Level output, one cycle behind the status bits
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(int_status & int_mask_q);
  end

  // ==========================================================
  // Read view of the hub status register
  // Command bits and local power bits always read back as zero
  always @*
  begin
    hub_status_rd = `RH_RESET_WORD; // RULE_13
    hub_status_rd[`RH_HS_CLR_RWE] = 1'b0; // RULE_02
    hub_status_rd[`RH_HS_OC_CHANGE] = hub_oc_change;
    hub_status_rd[`RH_HS_SET_GPWR] = 1'b0; // RULE_05
    hub_status_rd[`RH_HS_RWE] = remote_wake_enable_q; // RULE_07
    hub_status_rd[`RH_HS_OC] = hub_overcurrent_flag_q; // RULE_09
    hub_status_rd[`RH_HS_CLR_GPWR] = 1'b0; // RULE_11
  end

  // ==========================================================
  // Read data multiplexer
  // Reserved bits and unmapped addresses read as zero
  always @*
  begin
    rdata_d = `RH_RESET_WORD;
    case (sel)
      6'h01: rdata_d = hub_status_rd;
      6'h02: rdata_d = port_rdata[0];
      6'h04: rdata_d = port_rdata[1];
      6'h08:
      begin
        rdata_d[`RH_HC_NO_OC_PROT] = no_oc_protection_q;
        rdata_d[`RH_HC_OC_MODE] = oc_protection_mode_q;
        rdata_d[`RH_HC_PWR_MODE] = power_switching_mode_q;
      end
      6'h10: rdata_d[`RH_INT_WIDTH-1:0] = int_status;
      6'h20: rdata_d[`RH_INT_WIDTH-1:0] = int_mask_q;
      default: rdata_d = `RH_RESET_WORD;
    endcase
  end

endmodule // usb_host_root_hub_status

/* bench/usb_host_root_hub_status_assertions.sv */
// Port checks of the root hub status block
`include "rh_consts.vh"

module usb_host_root_hub_status_assertions #(
  parameter NUM_PORTS = 2
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Status outputs
  input wire logic [NUM_PORTS-1:0] port_power_o,
  input wire logic remote_wakeup_o,
  input wire logic irq_o
);
  // ==========================================================
  // Decode mirror
  wire logic mapped = paddr_i inside {`RH_ADDR_HUB_STATUS, `RH_ADDR_PORT1_STATUS,
    `RH_ADDR_PORT2_STATUS, `RH_ADDR_HUB_CONTROL, `RH_ADDR_INT_STATUS, `RH_ADDR_INT_MASK};
  wire logic hub_rd = pready_o && !pwrite_i && paddr_i == `RH_ADDR_HUB_STATUS;
  wire logic acc = psel_i && penable_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Properties
  a_ready_access: assert property (acc |-> pready_o)
    else $error("pready missing in access cycle");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside answer");
  a_err_decode: assert property (acc |-> pslverr_o == !mapped)
    else $error("error response wrong for address");
  a_err_zero_data: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  a_hub_fixed_zero: assert property (hub_rd |-> !prdata_o[31] && !prdata_o[16] && !prdata_o[0])
    else $error("command bit read as one");
  a_wake_pulse: assert property (remote_wakeup_o |=> !remote_wakeup_o)
    else $error("wakeup longer than one cycle");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && port_power_o == '0 && !pready_o)
    else $error("outputs busy after reset");
  a_power_hold: assert property (!(acc && pwrite_i) && !$past(acc && pwrite_i) |=> $stable(port_power_o))
    else $error("port power moved without a write");
endmodule // usb_host_root_hub_status_assertions

bind usb_host_root_hub_status usb_host_root_hub_status_assertions #(.NUM_PORTS(NUM_PORTS)) chk_i (
  .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
  .pslverr_o, .port_power_o, .remote_wakeup_o, .irq_o);

/* bench/usb_downstream_model.sv */
// Model of the devices on the two downstream ports
module usb_downstream_model #(
  parameter int SETTLE = 3
) (
  // Clock
  input wire logic clk_i,
  // Requests from the bench
  input wire logic [1:0] plug_i,
  input wire logic [1:0] oc_i,
  input wire logic [5:0] evt_i,
  // Lines towards the port logic
  output logic [1:0] connect_o = '0,
  output logic [1:0] oc_o = '0,
  output logic [5:0] evt_o = '0
);
  logic [5:0] evt_q = '0;
  int cnt = 0;
  // Attach only lands after the plug has settled, so detection is never instant
  always @(posedge clk_i)
  begin
    evt_q <= evt_i;
    evt_o <= evt_i & ~evt_q;
    oc_o <= oc_i;
    if (plug_i == connect_o || cnt == SETTLE)
    begin
      connect_o <= plug_i;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // usb_downstream_model

/* bench/usb_host_root_hub_status_tb_top.sv */
// Self-checking bench of the root hub status block
`include "rh_consts.vh"

module usb_host_root_hub_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] HUB = `RH_ADDR_HUB_STATUS;
  localparam logic [31:0] P1 = `RH_ADDR_PORT1_STATUS;
  localparam logic [31:0] P2 = `RH_ADDR_PORT2_STATUS;
  localparam logic [31:0] CTL = `RH_ADDR_HUB_CONTROL;
  localparam logic [31:0] IST = `RH_ADDR_INT_STATUS;
  localparam logic [31:0] IMK = `RH_ADDR_INT_MASK;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oc_pin = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd_q, d;
  logic pready, pslverr, wake, irq, err_q, seen, exp_wake;
  logic [1:0] plug = '0, poc = '0, conn, pocw, power, exp_pwr;
  logic [5:0] evt = '0, evt_p;
  int num_errors = 0;
  int samples_checked = 0;

  // ==========================================================
  // Clock and instances
  always #4 clk_i = ~clk_i;
  usb_host_root_hub_status usb_host_root_hub_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .overcurrent_input_pin_i(oc_pin), .port_connect_i(conn), .port_overcurrent_i(pocw),
    .port_enable_lost_i(evt_p[1:0]), .port_resume_done_i(evt_p[3:2]),
    .port_reset_done_i(evt_p[5:4]), .port_power_o(power), .remote_wakeup_o(wake),
    .irq_o(irq));
  usb_downstream_model usb_downstream_model_i (.clk_i(clk_i), .plug_i(plug), .oc_i(poc),
    .evt_i(evt), .connect_o(conn), .oc_o(pocw), .evt_o(evt_p));

  // ==========================================================
  // Tasks and expectations
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Settling cycles after release keep reads clear of register pipelines
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd_q);
  endtask
  task automatic watch_wake;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk_i);
      if (wake === 1'b1) seen = 1'b1;
    end
  endtask
  function automatic logic next_wake(input logic [31:0] v, input logic cur);
    return v[31] ? 1'b0 : (v[15] ? 1'b1 : cur);
  endfunction
  function automatic logic [1:0] next_pwr(input logic [31:0] v, input logic [1:0] cur);
    return v[16] ? 2'b11 : (v[0] ? 2'b00 : cur);
  endfunction
  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog far beyond the several hundred cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hE6C8));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc(HUB, 32'h0000_0000);
    rdc(P1, 32'h0000_0000);
    rdc(P2, 32'h0000_0000);
    apb(1'b1, HUB, 32'h0000_8000);
    rdc(HUB, 32'h0000_8000);
    apb(1'b1, HUB, 32'h0000_0000);
    rdc(HUB, 32'h0000_8000);
    plug <= 2'b01;
    watch_wake();
    chk("wakeup", 32'h1, {31'h0, seen});
    rdc(P1, 32'h0001_0001);
    apb(1'b1, P1, 32'h0001_0000);
    rdc(P1, 32'h0000_0001);
    apb(1'b1, HUB, 32'h8000_8000);
    rdc(HUB, 32'h0000_0000);
    plug <= 2'b11;
    watch_wake();
    chk("wakeup", 32'h0, {31'h0, seen});
    rdc(P2, 32'h0001_0001);
    oc_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(HUB, 32'h0002_0002);
    apb(1'b1, HUB, 32'h0000_0000);
    rdc(HUB, 32'h0002_0002);
    apb(1'b1, HUB, 32'h0002_0000);
    rdc(HUB, 32'h0000_0002);
    apb(1'b1, CTL, 32'h0000_1000);
    rdc(HUB, 32'h0002_0000);
    apb(1'b1, CTL, 32'h0000_0800);
    rdc(HUB, 32'h0002_0000);
    apb(1'b1, CTL, 32'h0000_0000);
    rdc(HUB, 32'h0002_0002);
    apb(1'b1, IST, 32'h0000_000F);
    apb(1'b1, IMK, 32'h0000_0001);
    oc_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, IMK, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, IMK, 32'h0000_0001);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, IST, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(HUB, 32'h0002_0000);
    apb(1'b1, HUB, 32'h0003_0000);
    chk("power", 32'h3, {30'h0, power});
    rdc(P1, 32'h0000_0101);
    apb(1'b1, HUB, 32'h0000_0000);
    chk("power", 32'h3, {30'h0, power});
    apb(1'b1, HUB, 32'h0000_0001);
    chk("power", 32'h0, {30'h0, power});
    apb(1'b1, CTL, 32'h0000_0100);
    apb(1'b1, HUB, 32'h0001_0000);
    chk("power", 32'h0, {30'h0, power});
    apb(1'b1, P1, 32'h0000_0100);
    chk("power", 32'h1, {30'h0, power});
    apb(1'b1, P1, 32'h0000_0200);
    chk("power", 32'h0, {30'h0, power});
    apb(1'b1, CTL, 32'h0000_0000);
    apb(1'b1, CTL, 32'h0000_0800);
    poc <= 2'b01;
    repeat (4) @(posedge clk_i);
    rdc(P1, 32'h0008_0009);
    rdc(HUB, 32'h0000_0000);
    poc <= 2'b00;
    apb(1'b1, P1, 32'h0008_0000);
    rdc(P1, 32'h0008_0001);
    apb(1'b1, P1, 32'h0008_0000);
    rdc(P1, 32'h0000_0001);
    apb(1'b1, CTL, 32'h0000_0000);
    apb(1'b0, 32'hB000_705C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_q});
    chk("unmapped data", 32'h0, rd_q);
    evt <= 6'h3F;
    repeat (3) @(posedge clk_i);
    evt <= 6'h00;
    rdc(P1, 32'h0016_0001);
    exp_wake = 1'b0;
    exp_pwr = 2'b00;
    repeat (24)
    begin
      d = $urandom;
      apb(1'b1, HUB, d);
      exp_wake = next_wake(d, exp_wake);
      exp_pwr = next_pwr(d, exp_pwr);
      rdc(HUB, {16'h0, exp_wake, 15'h0});
      chk("power", {30'h0, exp_pwr}, {30'h0, power});
    end
    test_done();
  end
endmodule // usb_host_root_hub_status_tb_top
